// ===== ufb_pkg.sv
// Shared constants and carrier types for the USART frame and baud setup.
package ufb_pkg;

  // Register indices; byte address on the bus is four times the index.
  localparam logic [3:0] UFB_IDX_RX_MODE = 4'h6;
  localparam logic [3:0] UFB_IDX_FRAME = 4'h7;
  localparam logic [3:0] UFB_IDX_BAUD_LO = 4'h8;
  localparam logic [3:0] UFB_IDX_BAUD_HI = 4'h9;
  localparam logic [3:0] UFB_IDX_ABAUD = 4'hA;

  // Reset values.
  localparam logic [7:0] UFB_FRAME_RST = 8'h03;
  localparam logic [7:0] UFB_ZERO_RST = 8'h00;

  // Field positions inside the byte registers.
  localparam int UFB_MODE_LSB = 6;
  localparam int UFB_PAR_LSB = 4;
  localparam int UFB_STOP_BIT = 3;
  localparam int UFB_SIZE_LSB = 0;
  localparam int UFB_ORDER_BIT = 2;
  localparam int UFB_PHASE_BIT = 1;
  localparam int UFB_RXM_LSB = 1;
  localparam int UFB_ABW_LSB = 6;

  // Bits that survive a write in each layout.
  localparam logic [7:0] UFB_SPI_MASK = 8'hC6;
  localparam logic [7:0] UFB_RXM_MASK = 8'h06;
  localparam logic [7:0] UFB_ABW_MASK = 8'hC0;

  // Communication modes.
  typedef enum logic [1:0] {
    UFB_ASYNC = 2'h0,
    UFB_SYNC = 2'h1,
    UFB_IRDA = 2'h2,
    UFB_MASTER_SPI_MODE = 2'h3
  } ufb_comm_mode_sel_t;

  // Receiver modes.
  typedef enum logic [1:0] {
    UFB_RX_NORMAL = 2'h0,
    UFB_RX_DOUBLE = 2'h1,
    UFB_RX_GENERIC_AUTOBAUD = 2'h2,
    UFB_RX_LIN_CONSTRAINED_AUTOBAUD = 2'h3
  } ufb_receiver_mode_sel_t;

  // Parity codes.
  localparam logic [1:0] UFB_PAR_EVEN = 2'h2;
  localparam logic [1:0] UFB_PAR_ODD = 2'h3;

  // Character size codes.
  localparam logic [2:0] UFB_SIZE_8 = 3'h3;
  localparam logic [2:0] UFB_SIZE_9L = 3'h6;
  localparam logic [2:0] UFB_SIZE_9H = 3'h7;
  localparam logic [3:0] UFB_BITS_MIN = 4'h5;
  localparam logic [3:0] UFB_BITS_8 = 4'h8;
  localparam logic [3:0] UFB_BITS_9 = 4'h9;

  // Auto-baud: 16 samples per bit, so a bit pair spans 32 samples.
  localparam int UFB_SAMPLES_PER_BIT = 16;
  localparam int UFB_PAIR_SAMPLES = 2 * UFB_SAMPLES_PER_BIT;
  localparam logic [3:0] UFB_TOL_W0 = 4'h6;
  localparam logic [3:0] UFB_TOL_W1 = 4'h5;
  localparam logic [3:0] UFB_TOL_W2 = 4'h7;
  localparam logic [3:0] UFB_TOL_W3 = 4'h8;

  // Decoded configuration handed to the datapaths.
  typedef struct packed {
    logic mode_async;
    logic mode_sync;
    logic mode_irda;
    logic master_spi_mode;
    logic parity_en;
    logic parity_odd;
    logic two_stop_bits;
    logic [3:0] data_bits;
    logic nine_bit_high_first;
    logic spi_lsb_first;
    logic spi_sample_trailing;
    logic [1:0] receiver_mode_sel;
    logic lin_constrained_autobaud;
    logic [3:0] window_tol;
  } ufb_cfg_t;

endpackage

// ===== ufb_frame_baud_cfg.sv
// Frame format, mode, baud and auto-baud window setup of the USART.
`timescale 1ns/100ps

// Operation
// RL1: Mode codes 0..3 mean asynchronous, synchronous, infrared, master SPI.
// RL2: Mode 3 switches the frame register to the master SPI layout.
// RL3: Parity 0 off, 1 reserved, 2 even, 3 odd.
// RL4: Stop select 0 sends one stop bit, 1 sends two.
// RL5: Receiver ignores the stop select setting.
// RL6: Size codes 0..3 give 5..8 bits, 4-5 reserved, 6-7 nine bits.
// RL7: Nine-bit code 6 accesses low byte first, code 7 high byte first.
// RL8: SPI layout keeps only mode, data order and clock phase, reset zero.
// RL9: SPI order bit clear sends MSB first, set sends LSB first.
// RL10: Software changes data order only while idle.
// RL11: SPI phase clear samples on leading edge, set on trailing edge.
// RL12: Baud is 16 bits, low byte at base, high byte at base plus one.
// RL13: A baud write reaches the prescaler immediately.
// RL14: Software changes baud only while no frame is in progress.
// RL15: Window codes 0..3 accept 32 plus or minus 6, 5, 7, 8.
// RL16: Sixteen samples per bit; a matched bit pair spans 32 samples.
// RL17: Window check applies only in LIN-constrained auto-baud mode.
// RL18: Receiver mode codes: normal, double speed, generic, LIN auto-baud.
// RL19: Parity covers the configured data bits only, sent before stop bits.
// RL20: Reserved parity and size codes fall back to the nearest setting.
module ufb_frame_baud_cfg
  import ufb_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [8:0] TX_CHAR,
  input wire logic PAIR_CNT_VALID,
  input wire logic [CNT_W-1:0] PAIR_CNT,
  output ufb_cfg_t CFG,
  output logic [15:0] BAUD_VALUE,
  output logic BAUD_RELOAD,
  output logic TX_PARITY_BIT,
  output logic WINDOW_OK,
  output logic WINDOW_ERR
);

  // The pair count must hold 32 plus the widest tolerance.
  if (CNT_W < 6 || CNT_W > 16)
  begin : g_check
    $error("CNT_W must lie between 6 and 16");
  end

  logic rst_meta_r;
  logic rst_n_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] frame_r;
  logic [7:0] rxm_r;
  logic [7:0] abw_r;
  logic [15:0] baud_r;
  logic reload_r;
  ufb_cfg_t cfg_r;
  logic par_r;
  logic ok_r;
  logic err_r;
  logic req;
  logic wr_go;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic [7:0] frame_view;
  logic [7:0] rd_nxt;
  ufb_cfg_t cfg_nxt;
  logic [8:0] bit_mask;
  logic par_nxt;
  logic [CNT_W-1:0] lo_bound;
  logic [CNT_W-1:0] hi_bound;

  // Reset is released through two flops so every register leaves reset
  // on the same edge, away from the asynchronous release.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Bus decode; only byte lane 0 carries register data.
  assign req = AVS_READ | AVS_WRITE;
  assign idx = AVS_ADDRESS[5:2];
  assign wbyte = AVS_WRITEDATA[7:0];
  assign wr_go = AVS_WRITE & ~wait_r & AVS_BYTEENABLE[0];

  // Every access waits exactly one cycle; the write lands and the read
  // data stand on the edge where the master sees waitrequest low.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      wait_r <= 1'b1;
    else if (req && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  // In master SPI mode the unused bits read as zero.
  always_comb
  begin
    if (frame_r[UFB_MODE_LSB +: 2] == UFB_MASTER_SPI_MODE) // RL2
      frame_view = frame_r & UFB_SPI_MASK; // RL8
    else
      frame_view = frame_r;
  end

  // Read mux; unmapped indices read as zero.
  always_comb
  begin
    rd_nxt = UFB_ZERO_RST;
    unique case (idx)
      UFB_IDX_RX_MODE: rd_nxt = rxm_r;
      UFB_IDX_FRAME: rd_nxt = frame_view;
      UFB_IDX_BAUD_LO: rd_nxt = baud_r[7:0]; // RL12
      UFB_IDX_BAUD_HI: rd_nxt = baud_r[15:8]; // RL12
      UFB_IDX_ABAUD: rd_nxt = abw_r;
      default: rd_nxt = UFB_ZERO_RST;
    endcase
  end

  // Read data is captured while waitrequest is still high.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rdata_r <= 32'h0000_0000;
    else if (AVS_READ && wait_r)
      rdata_r <= {24'h00_0000, rd_nxt};
  end

  // Frame control; a write that selects master SPI keeps only the SPI
  // fields so the normal fields come back at their zero values.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      frame_r <= UFB_FRAME_RST;
    else if (wr_go && idx == UFB_IDX_FRAME)
    begin
      if (wbyte[UFB_MODE_LSB +: 2] == UFB_MASTER_SPI_MODE) // RL2
        frame_r <= wbyte & UFB_SPI_MASK; // RL8
      else
        frame_r <= wbyte;
    end
  end

  // Receiver mode and auto-baud window registers.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rxm_r <= UFB_ZERO_RST;
      abw_r <= UFB_ZERO_RST;
    end
    else if (wr_go && idx == UFB_IDX_RX_MODE)
      rxm_r <= wbyte & UFB_RXM_MASK;
    else if (wr_go && idx == UFB_IDX_ABAUD)
      abw_r <= wbyte & UFB_ABW_MASK;
  end

  // Baud bytes feed the prescaler directly, with a reload pulse so the
  // prescaler restarts at once. Mid-frame writes corrupt that frame.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      baud_r <= 16'h0000;
      reload_r <= 1'b0;
    end
    else
    begin
      reload_r <= 1'b0;
      if (wr_go && idx == UFB_IDX_BAUD_LO)
      begin
        baud_r[7:0] <= wbyte; // RL12
        reload_r <= 1'b1; // RL13
      end
      else if (wr_go && idx == UFB_IDX_BAUD_HI)
      begin
        baud_r[15:8] <= wbyte; // RL12
        reload_r <= 1'b1; // RL13
      end
    end
  end

  // Decode of the stored fields into the configuration carrier.
  always_comb
  begin
    cfg_nxt = '0;
    cfg_nxt.mode_async = frame_r[UFB_MODE_LSB +: 2] == UFB_ASYNC; // RL1
    cfg_nxt.mode_sync = frame_r[UFB_MODE_LSB +: 2] == UFB_SYNC; // RL1
    cfg_nxt.mode_irda = frame_r[UFB_MODE_LSB +: 2] == UFB_IRDA; // RL1
    cfg_nxt.master_spi_mode = frame_r[UFB_MODE_LSB +: 2] == UFB_MASTER_SPI_MODE; // RL1
    cfg_nxt.receiver_mode_sel = rxm_r[UFB_RXM_LSB +: 2]; // RL18
    cfg_nxt.lin_constrained_autobaud =
      rxm_r[UFB_RXM_LSB +: 2] == UFB_RX_LIN_CONSTRAINED_AUTOBAUD; // RL18
    unique case (abw_r[UFB_ABW_LSB +: 2]) // RL15
      2'h0: cfg_nxt.window_tol = UFB_TOL_W0;
      2'h1: cfg_nxt.window_tol = UFB_TOL_W1;
      2'h2: cfg_nxt.window_tol = UFB_TOL_W2;
      2'h3: cfg_nxt.window_tol = UFB_TOL_W3;
    endcase
    if (cfg_nxt.master_spi_mode)
    begin
      // SPI frames are always eight bits with no parity or stop bits.
      cfg_nxt.data_bits = UFB_BITS_8;
      cfg_nxt.spi_lsb_first = frame_r[UFB_ORDER_BIT]; // RL9
      cfg_nxt.spi_sample_trailing = frame_r[UFB_PHASE_BIT]; // RL11
    end
    else
    begin
      // Reserved parity code 1 behaves as parity off.
      cfg_nxt.parity_en = frame_r[UFB_PAR_LSB + 1]; // RL3 RL20
      cfg_nxt.parity_odd =
        frame_r[UFB_PAR_LSB +: 2] == UFB_PAR_ODD; // RL3
      // Only the transmitter reads this; the receiver checks one stop.
      cfg_nxt.two_stop_bits = frame_r[UFB_STOP_BIT]; // RL4 RL5
      if (frame_r[UFB_SIZE_LSB +: 3] == UFB_SIZE_9L ||
          frame_r[UFB_SIZE_LSB +: 3] == UFB_SIZE_9H)
        cfg_nxt.data_bits = UFB_BITS_9; // RL6
      else if (frame_r[UFB_SIZE_LSB +: 3] > UFB_SIZE_8)
        cfg_nxt.data_bits = UFB_BITS_8; // RL20
      else
        cfg_nxt.data_bits =
          UFB_BITS_MIN + {1'b0, frame_r[UFB_SIZE_LSB +: 3]}; // RL6
      cfg_nxt.nine_bit_high_first =
        frame_r[UFB_SIZE_LSB +: 3] == UFB_SIZE_9H; // RL7
    end
  end

  // One mask bit per data position covers only the configured bits.
  for (genvar i = 0; i < 9; i++)
  begin : g_mask
    assign bit_mask[i] = 4'(i) < cfg_nxt.data_bits; // RL19
  end

  // The parity bit follows the last data bit and precedes the stop bits.
  assign par_nxt = (^(TX_CHAR & bit_mask)) ^ cfg_nxt.parity_odd; // RL19

  // Configuration and parity outputs, registered.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cfg_r <= '0;
      par_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      par_r <= par_nxt & cfg_nxt.parity_en; // RL3
    end
  end

  // Accepted span around the 32-sample reference for a bit pair.
  assign lo_bound = CNT_W'(UFB_PAIR_SAMPLES) -
    {{(CNT_W-4){1'b0}}, cfg_nxt.window_tol}; // RL16
  assign hi_bound = CNT_W'(UFB_PAIR_SAMPLES) +
    {{(CNT_W-4){1'b0}}, cfg_nxt.window_tol}; // RL16

  // Window check; outside LIN auto-baud every count is accepted.
  always_ff @(posedge MCLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ok_r <= 1'b1;
      err_r <= 1'b0;
    end
    else
    begin
      err_r <= 1'b0;
      if (PAIR_CNT_VALID)
      begin
        if (!cfg_nxt.lin_constrained_autobaud) // RL17
          ok_r <= 1'b1;
        else if (PAIR_CNT < lo_bound || PAIR_CNT > hi_bound) // RL15
        begin
          ok_r <= 1'b0;
          err_r <= 1'b1;
        end
        else
          ok_r <= 1'b1;
      end
    end
  end

  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA = rdata_r;
  assign CFG = cfg_r;
  assign BAUD_VALUE = baud_r;
  assign BAUD_RELOAD = reload_r;
  assign TX_PARITY_BIT = par_r;
  assign WINDOW_OK = ok_r;
  assign WINDOW_ERR = err_r;

endmodule

// ===== ufb_cfg_checker_properties.sv
// Concurrent checks on the ports of the frame and baud setup block.
`timescale 1ns/100ps
module ufb_cfg_checker
  import ufb_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic PAIR_CNT_VALID,
  input wire logic [CNT_W-1:0] PAIR_CNT,
  input wire ufb_cfg_t CFG,
  input wire logic [15:0] BAUD_VALUE,
  input wire logic BAUD_RELOAD,
  input wire logic TX_PARITY_BIT,
  input wire logic WINDOW_OK,
  input wire logic WINDOW_ERR
);
  logic wr_ok;
  logic in_win;
  // A write lands only at its completing edge, and only with lane 0 on.
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  // The window is inclusive at both ends.
  assign in_win =
    int'(PAIR_CNT) >= UFB_PAIR_SAMPLES - int'(CFG.window_tol) &&
    int'(PAIR_CNT) <= UFB_PAIR_SAMPLES + int'(CFG.window_tol);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  a_wait_one:
  assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus answer late");
  a_wait_pulse:
  assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  a_baud_reload:
  assert property (wr_ok && AVS_ADDRESS[5:3] == 3'h4 |=> BAUD_RELOAD)
    else $error("no reload after baud write");
  a_baud_low:
  assert property (wr_ok && AVS_ADDRESS[5:2] == UFB_IDX_BAUD_LO
    |=> BAUD_VALUE[7:0] == $past(AVS_WRITEDATA[7:0])
    && $stable(BAUD_VALUE[15:8])) else $error("baud low byte");
  a_baud_high:
  assert property (wr_ok && AVS_ADDRESS[5:2] == UFB_IDX_BAUD_HI
    |=> BAUD_VALUE[15:8] == $past(AVS_WRITEDATA[7:0])
    && $stable(BAUD_VALUE[7:0])) else $error("baud high byte");
  a_win_lin:
  assert property (PAIR_CNT_VALID && CFG.lin_constrained_autobaud
    |=> WINDOW_OK == $past(in_win) && WINDOW_ERR != $past(in_win))
    else $error("window result wrong");
  a_win_other:
  assert property (PAIR_CNT_VALID && !CFG.lin_constrained_autobaud
    |=> WINDOW_OK && !WINDOW_ERR) else $error("window checked off mode");
  a_par_off:
  assert property (!CFG.parity_en ##1 !CFG.parity_en |-> !TX_PARITY_BIT)
    else $error("parity bit while disabled");
  a_spi_plain:
  assert property (CFG.master_spi_mode |-> !CFG.parity_en
    && !CFG.two_stop_bits && CFG.data_bits == UFB_BITS_8)
    else $error("normal fields alive in spi");
  c_reload: cover property (BAUD_RELOAD);
  c_win_err: cover property (CFG.lin_constrained_autobaud && WINDOW_ERR);
  c_spi: cover property (CFG.master_spi_mode);
endmodule

// ===== ufb_station_model.sv
// Remote station model: line-side bit-pair counts and characters.
`timescale 1ns/100ps
module ufb_station_model
(
  input wire logic clk,
  output logic cnt_valid,
  output logic [7:0] cnt,
  output logic [8:0] chr
);
  initial
  begin
    cnt_valid = 1'b0;
    cnt = 8'h20;
    chr = 9'h000;
  end
  // A count is shown for one cycle; afterwards the bus shows junk.
  task automatic send_pair(input logic [7:0] c);
    @(posedge clk);
    cnt_valid <= 1'b1;
    cnt <= c;
    @(posedge clk);
    cnt_valid <= 1'b0;
    cnt <= ~c;
  endtask
  // A new character offered for transmission.
  task automatic send_char(input logic [8:0] c);
    @(posedge clk);
    chr <= c;
  endtask
endmodule

// ===== usart_frame_baud_config_tb.sv
// Self-checking bench of the USART frame and baud setup.
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
  end
module usart_frame_baud_config_tb;
  import ufb_pkg::*;
  localparam int CNT_W = 8;
  logic mclk = 1'b0;
  logic reset_n, avs_read, avs_write, reload, par_bit, win_ok, win_err;
  logic [5:0] avs_address;
  logic [3:0] avs_be;
  logic [31:0] avs_wdata, avs_rdata, seed;
  logic avs_wait, stn_valid, pe, ep, ok;
  logic [7:0] stn_cnt, q;
  logic [8:0] stn_chr;
  logic [15:0] baud;
  ufb_cfg_t cfg;
  int num_errors = 0, comparisons = 0, cycles = 0;
  int f, m, p, s, nb, a, c, tol;
  ufb_frame_baud_cfg #(.CNT_W(CNT_W)) i_dut (.MCLK(mclk), .RESET_N(reset_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_BYTEENABLE(avs_be), .AVS_WRITEDATA(avs_wdata),
    .AVS_READDATA(avs_rdata), .AVS_WAITREQUEST(avs_wait), .TX_CHAR(stn_chr),
    .PAIR_CNT_VALID(stn_valid), .PAIR_CNT(stn_cnt), .CFG(cfg),
    .BAUD_VALUE(baud), .BAUD_RELOAD(reload), .TX_PARITY_BIT(par_bit),
    .WINDOW_OK(win_ok), .WINDOW_ERR(win_err));
  ufb_station_model i_stn (.clk(mclk), .cnt_valid(stn_valid),
    .cnt(stn_cnt), .chr(stn_chr));
  // Free-running clock with a 100 ns period.
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // A hang is cut short well beyond the few thousand cycles needed.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      final_report();
    end
  end
  // Xorshift step that feeds the random stimulus.
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Prints the counts, then the verdict, and ends the run.
  task final_report();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One bus access; the request holds until waitrequest is seen low.
  task bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_wdata <= {24'h000000, d};
    avs_be <= be;
    do
      @(posedge mclk);
    while (avs_wait !== 1'b0);
    q = avs_rdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Reads one register and compares its byte with the expected value.
  task rd(input logic [3:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'hF);
    `CHK(q, e)
  endtask
  initial
  begin
    reset_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_be, avs_wdata} = '0;
    seed = 32'h8E17D4E6;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset contents, then an unmapped place that must stay empty.
    rd(UFB_IDX_RX_MODE, 8'h00);
    rd(UFB_IDX_FRAME, UFB_FRAME_RST);
    rd(UFB_IDX_BAUD_LO, 8'h00);
    rd(UFB_IDX_BAUD_HI, 8'h00);
    rd(UFB_IDX_ABAUD, 8'h00);
    @(negedge mclk);
    `CHK({win_ok, win_err}, 2'b10)
    bus(1'b1, 4'hF, 8'hFF, 4'hF);
    rd(4'hF, 8'h00);
    $display("reset test done");
    // Every frame byte, reserved codes and the spi layout included.
    for (f = 0; f < 256; f++)
    begin
      m = f[7:6];
      p = f[5:4];
      s = f[2:0];
      bus(1'b1, UFB_IDX_FRAME, f[7:0], 4'h1);
      rd(UFB_IDX_FRAME, (m == 3) ? f[7:0] & UFB_SPI_MASK : f[7:0]);
      seed = xs(seed);
      i_stn.send_char(seed[8:0]);
      @(posedge mclk);
      @(negedge mclk);
      nb = (m == 3) ? 8 : (s < 4) ? s + 5 : (s < 6) ? 8 : 9;
      pe = m != 3 && p >= 2;
      ep = pe && ((^(seed[8:0] & ((9'h1 << nb) - 1))) ^ (p == 3));
      `CHK(par_bit, ep)
      `CHK({cfg.mode_async, cfg.mode_sync, cfg.mode_irda,
        cfg.master_spi_mode}, 4'h8 >> m)
      `CHK({cfg.parity_en, cfg.parity_odd}, {pe, pe && p == 3})
      `CHK(cfg.two_stop_bits, m != 3 && f[3])
      `CHK(cfg.data_bits, nb[3:0])
      `CHK(cfg.nine_bit_high_first, m != 3 && s == 7)
      if (m == 3)
        `CHK({cfg.spi_lsb_first, cfg.spi_sample_trailing}, f[2:1])
    end
    $display("frame test done");
    // Baud bytes apart; each write is made while the line is idle.
    for (a = 0; a < 8; a++)
    begin
      seed = xs(seed);
      bus(1'b1, UFB_IDX_BAUD_LO, seed[7:0], 4'h1);
      @(negedge mclk);
      `CHK(baud[7:0], seed[7:0])
      `CHK(reload, 1'b1)
      bus(1'b1, UFB_IDX_BAUD_HI, seed[15:8], 4'h1);
      @(negedge mclk);
      `CHK(baud, seed[15:0])
      bus(1'b1, UFB_IDX_BAUD_LO, ~seed[7:0], 4'h0);
      @(negedge mclk);
      `CHK(reload, 1'b0)
      rd(UFB_IDX_BAUD_HI, seed[15:8]);
      `CHK(baud, seed[15:0])
    end
    $display("baud test done");
    // Window edges for every width code, then the other receiver modes.
    bus(1'b1, UFB_IDX_RX_MODE, 8'hFF, 4'h1);
    rd(UFB_IDX_RX_MODE, UFB_RXM_MASK);
    for (a = 0; a < 4; a++)
    begin
      bus(1'b1, UFB_IDX_ABAUD, {a[1:0], 6'h3F}, 4'h1);
      rd(UFB_IDX_ABAUD, {a[1:0], 6'h00});
      tol = (a == 0) ? 6 : (a == 1) ? 5 : (a == 2) ? 7 : 8;
      `CHK({cfg.lin_constrained_autobaud, cfg.window_tol},
        {1'b1, tol[3:0]})
      for (c = 20; c < 45; c++)
      begin
        i_stn.send_pair(c[7:0]);
        @(negedge mclk);
        ok = c >= 32 - tol && c <= 32 + tol;
        `CHK({win_ok, win_err}, {ok, !ok})
      end
    end
    for (a = 0; a < 3; a++)
    begin
      bus(1'b1, UFB_IDX_RX_MODE, {5'h00, a[1:0], 1'b0}, 4'h1);
      i_stn.send_pair(8'h00);
      @(negedge mclk);
      `CHK({win_ok, win_err}, 2'b10)
      `CHK({cfg.receiver_mode_sel, cfg.lin_constrained_autobaud},
        {a[1:0], 1'b0})
    end
    $display("window test done");
    final_report();
  end
endmodule
bind ufb_frame_baud_cfg ufb_cfg_checker #(.CNT_W(CNT_W)) i_chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PAIR_CNT_VALID(PAIR_CNT_VALID),
  .PAIR_CNT(PAIR_CNT), .CFG(CFG), .BAUD_VALUE(BAUD_VALUE),
  .BAUD_RELOAD(BAUD_RELOAD), .TX_PARITY_BIT(TX_PARITY_BIT),
  .WINDOW_OK(WINDOW_OK), .WINDOW_ERR(WINDOW_ERR));
